// ===== inc/nvs_pkg.sv
// nvs_pkg: shared constants and types for the nvsram host controller
package nvs_pkg;

  // clock and counter width
  localparam int NVS_CLK_NS = 25;
  localparam int NVS_TW     = 19;

  // pin widths
  localparam int NVS_AW = 13;
  localparam int NVS_DW = 8;

  // times in their own units
  localparam int NVS_PWRUP_US   = 550;  // powerup_load_time
  localparam int NVS_STORE_MS   = 10;
  localparam int NVS_RECALL_US  = 20;
  localparam int NVS_DELAY_US   = 1;    // cycle_finish_window
  localparam int NVS_BUSY_NS    = 300;  // store request to busy low
  localparam int NVS_RECOVER_NS = 700;
  localparam int NVS_PULSE_NS   = 15;
  localparam int NVS_ACC_NS     = 55;   // slowest access/cycle figure

  // waits are least times, so every count rounds up
  localparam int NVS_PWRUP_CYC =
    (NVS_PWRUP_US * 1000 + NVS_CLK_NS - 1) / NVS_CLK_NS;
  localparam int NVS_STORE_CYC =
    (NVS_STORE_MS * 1000000 + NVS_CLK_NS - 1) / NVS_CLK_NS;
  localparam logic [NVS_TW-1:0] NVS_RECALL_CYC =
    NVS_TW'((NVS_RECALL_US * 1000 + NVS_CLK_NS - 1) / NVS_CLK_NS);
  localparam logic [NVS_TW-1:0] NVS_WATCH_CYC =
    NVS_TW'((NVS_DELAY_US * 1000 + NVS_BUSY_NS + NVS_CLK_NS - 1)
            / NVS_CLK_NS);
  localparam logic [NVS_TW-1:0] NVS_RECOVER_CYC =
    NVS_TW'((NVS_RECOVER_NS + NVS_CLK_NS - 1) / NVS_CLK_NS);
  localparam logic [NVS_TW-1:0] NVS_PULSE_CYC =
    NVS_TW'((NVS_PULSE_NS + NVS_CLK_NS - 1) / NVS_CLK_NS);
  localparam logic [NVS_TW-1:0] NVS_ACC_CYC =
    NVS_TW'((NVS_ACC_NS + NVS_CLK_NS - 1) / NVS_CLK_NS);

  // software sequence addresses
  localparam logic [NVS_AW-1:0] NVS_SEQ0        = 13'h0000;
  localparam logic [NVS_AW-1:0] NVS_SEQ1        = 13'h1555;
  localparam logic [NVS_AW-1:0] NVS_SEQ2        = 13'h0AAA;
  localparam logic [NVS_AW-1:0] NVS_SEQ3        = 13'h1FFF;
  localparam logic [NVS_AW-1:0] NVS_SEQ4        = 13'h10F0;
  localparam logic [NVS_AW-1:0] NVS_SEQ_STORE   = 13'h0F0F;
  localparam logic [NVS_AW-1:0] NVS_SEQ_RECALL  = 13'h0F0E;
  localparam logic [2:0]        NVS_SEQ_LAST    = 3'h5;

  typedef enum logic [2:0] {
    NVS_OP_READ,
    NVS_OP_WRITE,
    NVS_OP_SW_STORE,
    NVS_OP_SW_RECALL,
    NVS_OP_HW_STORE
  } nvs_op_t;

  typedef struct packed {
    nvs_op_t             op;
    logic [NVS_AW-1:0]   addr;
    logic [NVS_DW-1:0]   wdata;
  } nvs_cmd_t;

endpackage

// ===== hw/nvs_timer.sv
// nvs_timer: down counter that times access phases and nonvolatile waits
`timescale 1ns/1ps
`default_nettype none
module nvs_timer
  import nvs_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic [NVS_TW-1:0] len,
  output logic                   done
);

  logic [NVS_TW-1:0] cnt;

  // load on start, then count down and park at zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= len;
    end else if (cnt != '0) begin
      cnt <= cnt - NVS_TW'(1);
    end
  end

  // done stays high once expired, so a caller may wait on other terms too
  assign done = (cnt <= NVS_TW'(1));

endmodule
`default_nettype wire

// ===== hw/nvs_ctrl.sv
// nvs_ctrl: host controller driving an nvsram through its parallel pins
// Contract
// RULE1: reads are issued only with write enable and busy pin high.
// RULE2: a thirteen-bit address selects one of 8,192 bytes.
// RULE3: read data is sampled while select and output enable stay low.
// RULE4: writes are issued only with busy pin high.
// RULE5: address is held from before a write until select rises.
// RULE6: write data is held valid through the rising select edge.
// RULE7: output enable stays high for the whole write.
// RULE8: device turns off its drivers if output enable is low in a write.
// RULE9: after reset the host waits the power-up load time.
// RULE10: no write state is held during the power-up load.
// RULE11: busy pin low from a supply drop holds off new accesses.
// RULE12: accesses in progress at busy low are simply finished.
// RULE13: save sequence reads 0000,1555,0AAA,1FFF,10F0,0F0F.
// RULE14: load sequence reads 0000,1555,0AAA,1FFF,10F0,0F0E.
// RULE15: sequence accesses are reads with write enable high.
// RULE16: each sequence step is framed by select falling and rising.
// RULE17: nothing else is issued between the six sequence reads.
// RULE18: a save erases then programs the nonvolatile copy.
// RULE19: during a save no access is issued.
// RULE20: after a save the host waits ten milliseconds.
// RULE21: after a software load the host waits twenty microseconds.
// RULE22: host waits for the busy pin release before resuming.
// RULE23: a load clears then refills the SRAM.
// RULE24: pin requested saves may be skipped when nothing was written.
// RULE25: under low supply no saves or writes are started. The host only sees the busy pin, so it starts them again once busy is released.
`timescale 1ns/1ps
`default_nettype none
module nvs_ctrl
  import nvs_pkg::*;
#(
  parameter logic [NVS_TW-1:0] PWRUP_CYC = NVS_TW'(NVS_PWRUP_CYC),
  parameter logic [NVS_TW-1:0] STORE_CYC = NVS_TW'(NVS_STORE_CYC)
)
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire nvs_cmd_t          cmd,
  output logic                   resp_valid,
  output logic [NVS_DW-1:0]      resp_rdata,
  output logic                   resp_err,
  output logic [NVS_AW-1:0]      addr_in,
  input  wire logic [NVS_DW-1:0] data_io_in,
  output logic [NVS_DW-1:0]      data_io_out,
  output logic                   data_io_oe_n,
  output logic                   chip_select_n,
  output logic                   write_enable_n,
  output logic                   output_enable_n,
  input  wire logic              hw_nv_request_busy_n_in,
  output logic                   hw_nv_request_busy_n_out,
  output logic                   hw_nv_request_busy_n_oe_n
);

  typedef enum logic [3:0] {
    S_RST, S_PWRUP, S_IDLE, S_SETUP, S_ACT, S_END,
    S_NVWAIT, S_REQPULSE, S_REQWAIT, S_BUSYWAIT, S_RECOVER
  } nvs_state_t;

  nvs_state_t        state;
  nvs_state_t        next_state;
  nvs_cmd_t          cur;
  logic [2:0]        step;
  logic              tmr_start;
  logic [NVS_TW-1:0] tmr_len;
  logic              tmr_done;
  logic              finish;
  logic              abort;
  logic              seq_op;
  logic              pin_free;

  assign pin_free = hw_nv_request_busy_n_in;
  assign seq_op   = (cur.op == NVS_OP_SW_STORE) ||
                    (cur.op == NVS_OP_SW_RECALL);

  // open drain: the pin is only ever pulled low
  assign hw_nv_request_busy_n_out = 1'b0;

  // new work only while the busy pin is high; the supply itself is not seen, so low supply holds work off only while busy is low
  assign cmd_ready = (state == S_IDLE) && pin_free; // see RULE11 RULE25

  // address of a sequence step; last one picks save or load
  function automatic logic [NVS_AW-1:0] seq_addr(input logic [2:0] s,
                                                 input nvs_op_t    op);
    case (s)
      3'h0:    seq_addr = NVS_SEQ0;
      3'h1:    seq_addr = NVS_SEQ1;
      3'h2:    seq_addr = NVS_SEQ2;
      3'h3:    seq_addr = NVS_SEQ3;
      3'h4:    seq_addr = NVS_SEQ4;
      default: seq_addr = (op == NVS_OP_SW_STORE) ? NVS_SEQ_STORE
                                                  : NVS_SEQ_RECALL;
    endcase
  endfunction

  nvs_timer u_timer (
    .mclk  (mclk),
    .rst   (rst),
    .start (tmr_start),
    .len   (tmr_len),
    .done  (tmr_done)
  );

  // sequencing of accesses and nonvolatile waits
  always_comb begin
    next_state = state;
    tmr_start  = 1'b0;
    tmr_len    = NVS_ACC_CYC;
    finish     = 1'b0;
    abort      = 1'b0;
    case (state)
      S_RST: begin
        tmr_start  = 1'b1;
        tmr_len    = PWRUP_CYC; // see RULE9
        next_state = S_PWRUP;
      end
      S_PWRUP: begin
        if (tmr_done && pin_free) begin // see RULE9 RULE10
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          if (cmd.op == NVS_OP_HW_STORE) begin
            tmr_start  = 1'b1;
            tmr_len    = NVS_PULSE_CYC;
            next_state = S_REQPULSE;
          end else begin
            next_state = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        tmr_start  = 1'b1;
        next_state = S_ACT;
      end
      S_ACT: begin
        if (tmr_done) begin
          next_state = S_END;
        end
      end
      S_END: begin
        if (seq_op && step != NVS_SEQ_LAST) begin
          // a busy device would break the run, so give up cleanly
          if (!pin_free) begin
            abort      = 1'b1;
            next_state = S_BUSYWAIT;
          end else begin
            next_state = S_SETUP; // see RULE17
          end
        end else if (seq_op) begin
          tmr_start  = 1'b1;
          tmr_len    = (cur.op == NVS_OP_SW_STORE)
                       ? STORE_CYC       // see RULE20
                       : NVS_RECALL_CYC; // see RULE21
          next_state = S_NVWAIT;
        end else begin
          finish     = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_NVWAIT: begin
        if (tmr_done && pin_free) begin // see RULE19 RULE22
          tmr_start  = 1'b1;
          tmr_len    = NVS_RECOVER_CYC;
          next_state = S_RECOVER;
        end
      end
      S_REQPULSE: begin
        if (tmr_done) begin
          tmr_start  = 1'b1;
          tmr_len    = NVS_WATCH_CYC; // see RULE12 RULE24
          next_state = S_REQWAIT;
        end
      end
      S_REQWAIT: begin
        if (tmr_done) begin
          next_state = S_BUSYWAIT;
        end
      end
      S_BUSYWAIT: begin
        if (pin_free) begin // see RULE22
          tmr_start  = 1'b1;
          tmr_len    = NVS_RECOVER_CYC;
          next_state = S_RECOVER;
        end
      end
      S_RECOVER: begin
        if (tmr_done) begin
          finish     = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: next_state = S_RST;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= S_RST;
    end else begin
      state <= next_state;
    end
  end

  // command capture and sequence step
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur  <= '{op: NVS_OP_READ, addr: '0, wdata: '0};
      step <= 3'h0;
    end else if (state == S_IDLE && next_state != S_IDLE) begin
      cur  <= cmd;
      step <= 3'h0;
    end else if (state == S_END && next_state == S_SETUP) begin
      step <= step + 3'h1;
    end
  end

  // address only moves with select high, so it is stable across a cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_in <= '0;
    end else if (state == S_IDLE && next_state == S_SETUP) begin
      addr_in <= (cmd.op == NVS_OP_SW_STORE || cmd.op == NVS_OP_SW_RECALL)
                 ? NVS_SEQ0 : cmd.addr; // see RULE2 RULE13 RULE14
    end else if (state == S_END && next_state == S_SETUP) begin // see RULE5
      addr_in <= seq_addr(step + 3'h1, cur.op); // see RULE13 RULE14
    end
  end

  // pins follow the next state so they never glitch; select frames a step
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chip_select_n             <= 1'b1;
      write_enable_n            <= 1'b1;
      output_enable_n           <= 1'b1;
      data_io_oe_n              <= 1'b1;
      data_io_out               <= '0;
      hw_nv_request_busy_n_oe_n <= 1'b1;
    end else begin
      chip_select_n   <= !(next_state == S_ACT); // see RULE16 RULE19
      write_enable_n  <= !(next_state == S_ACT &&
                           cur.op == NVS_OP_WRITE); // see RULE15 RULE4
      output_enable_n <= !(next_state == S_ACT &&
                           cur.op != NVS_OP_WRITE); // see RULE7 RULE1
      // data held one cycle past select rising for hold time
      data_io_oe_n    <= !((next_state == S_ACT || next_state == S_END) &&
                           cur.op == NVS_OP_WRITE); // see RULE6
      data_io_out     <= cur.wdata;
      hw_nv_request_busy_n_oe_n <= !(next_state == S_REQPULSE);
    end
  end

  // read data is taken on the last cycle with select low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_rdata <= '0;
    end else if (state == S_ACT && tmr_done && cur.op == NVS_OP_READ) begin
      resp_rdata <= data_io_in; // see RULE3
    end
  end

  // answer pulse; error marks a sequence broken by the busy pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_err   <= 1'b0;
    end else begin
      resp_valid <= finish;
      if (state == S_IDLE && next_state != S_IDLE) begin
        resp_err <= 1'b0;
      end else if (abort) begin
        resp_err <= 1'b1;
      end
    end
  end

  chk_oe_write: assert property ( // see RULE7
    @(posedge mclk) disable iff (rst)
    !write_enable_n |-> output_enable_n && !data_io_oe_n)
    else $error("output enable low during write");

  chk_addr_stable: assert property ( // see RULE5
    @(posedge mclk) disable iff (rst)
    $rose(chip_select_n) || !chip_select_n |-> $stable(addr_in))
    else $error("address moved while selected");

  chk_seq_read: assert property ( // see RULE15
    @(posedge mclk) disable iff (rst)
    seq_op && !chip_select_n |-> write_enable_n)
    else $error("write inside sequence");

  chk_pwrup_quiet: assert property ( // see RULE10
    @(posedge mclk) disable iff (rst)
    state == S_PWRUP |-> chip_select_n && write_enable_n)
    else $error("access during power-up load");

  chk_seq_last: assert property ( // see RULE13
    @(posedge mclk) disable iff (rst)
    state == S_NVWAIT && $past(state) == S_END |->
      addr_in == ((cur.op == NVS_OP_SW_STORE) ? NVS_SEQ_STORE
                                              : NVS_SEQ_RECALL))
    else $error("wrong last sequence address");

  chk_cs_pulse: assert property ( // see RULE16
    @(posedge mclk) disable iff (rst)
    $fell(chip_select_n) |-> (!chip_select_n) [*3] ##1 chip_select_n)
    else $error("select pulse length wrong");

  chk_nv_quiet: assert property ( // see RULE19
    @(posedge mclk) disable iff (rst)
    state == S_NVWAIT || state == S_BUSYWAIT |-> chip_select_n)
    else $error("access during nonvolatile cycle");

  chk_req_pulse: assert property ( // see RULE24
    @(posedge mclk) disable iff (rst)
    $fell(hw_nv_request_busy_n_oe_n) |=> hw_nv_request_busy_n_oe_n)
    else $error("store request pulse not one cycle");

  cov_sw_store: cover property (
    @(posedge mclk) disable iff (rst)
    resp_valid && cur.op == NVS_OP_SW_STORE);
  cov_sw_recall: cover property (
    @(posedge mclk) disable iff (rst)
    resp_valid && cur.op == NVS_OP_SW_RECALL);
  cov_write: cover property (
    @(posedge mclk) disable iff (rst)
    resp_valid && cur.op == NVS_OP_WRITE);
  cov_hw_store: cover property (
    @(posedge mclk) disable iff (rst)
    resp_valid && cur.op == NVS_OP_HW_STORE);

endmodule
`default_nettype wire

// ===== tb/nvs_dev_model.sv
// nvs_dev_model: behavioural nvsram device on the far side of the host pins
`timescale 1ns/1ps
`default_nettype none
module nvs_dev_model
  import nvs_pkg::*;
#(
  parameter int STORE_CYC  = 120,
  parameter int RECALL_CYC = 10,
  parameter int WATCH_CYC  = 40
)
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              pwr_low,
  input  wire logic [NVS_AW-1:0] addr_in,
  input  wire logic              chip_select_n,
  input  wire logic              write_enable_n,
  input  wire logic              output_enable_n,
  input  wire logic [NVS_DW-1:0] dq_in,
  input  wire logic              busy_pin,
  output logic [NVS_DW-1:0]      dq_out,
  output logic                   dq_drv,
  output logic                   busy_pull
);
  localparam logic [NVS_AW-1:0] SEQ [0:4] =
    '{NVS_SEQ0, NVS_SEQ1, NVS_SEQ2, NVS_SEQ3, NVS_SEQ4};
  logic [NVS_DW-1:0] sram [0:8191];
  logic [NVS_DW-1:0] nv   [0:8191];
  logic [NVS_DW-1:0] last;
  logic [1:0]        mode;   // 0 sram, 1 save, 2 load, 3 supply watch
  int                cnt;
  int                step;
  logic              written;
  logic              p_cs;
  logic              p_we;
  logic              p_pwr;

  // nonvolatile copy starts with a known pattern so a load is visible
  initial for (int i = 0; i < 8192; i++) nv[i] = 8'(i) ^ 8'h5A;

  // drivers on only for a plain read; a low write enable turns them off
  assign dq_drv = !chip_select_n && !output_enable_n
                  && write_enable_n
                  && busy_pin && mode == 2'h0;
  // released bus shows the inverse of the last byte, never a stale copy
  assign dq_out = dq_drv ? sram[addr_in] : ~last;

  // pins are sampled on the host clock, so edges are seen one cycle late
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode      <= 2'h2;
      cnt       <= RECALL_CYC;
      step      <= 0;
      written   <= 1'b0;
      busy_pull <= 1'b0;
      p_cs      <= 1'b1;
      p_we      <= 1'b1;
      p_pwr     <= 1'b0;
      last      <= 8'h00;
    end else begin
      p_cs  <= chip_select_n;
      p_we  <= write_enable_n;
      p_pwr <= pwr_low;
      if (dq_drv) last <= dq_out;
      if (mode != 2'h0) begin
        cnt <= cnt - 1;
        if (cnt == 1 && mode == 2'h1) begin
          nv = '{default: 8'hFF};
          nv = sram;
          busy_pull <= 1'b0;
          written   <= 1'b0;
          mode      <= 2'h0;
        end else if (cnt == 1 && mode == 2'h2) begin
          sram = '{default: 8'h00};
          sram = nv;
          written <= 1'b0;
          mode    <= 2'h0;
        end else if (cnt == 1 && written) begin
          mode <= 2'h1;
          cnt  <= STORE_CYC;
        end else if (cnt == 1) begin
          busy_pull <= 1'b0;
          mode      <= 2'h0;
        end
      end else if (pwr_low && !p_pwr) begin
        mode      <= 2'h3;
        cnt       <= WATCH_CYC;
        busy_pull <= 1'b1;
        step      <= 0;
      end else if (!busy_pin && !pwr_low) begin
        // a pin request without a prior write is dropped
        if (written) begin
          mode      <= 2'h1;
          cnt       <= STORE_CYC;
          busy_pull <= 1'b1;
        end
      end else if (!p_cs && !p_we && (chip_select_n || write_enable_n)) begin
        if (busy_pin && !pwr_low) begin
          sram[addr_in] = dq_in;
          written <= 1'b1;
        end
        step <= 0;
      end else if (!p_cs && p_we && chip_select_n) begin
        if (step == 5 && addr_in == NVS_SEQ_STORE) begin
          mode      <= 2'h1;
          cnt       <= STORE_CYC;
          busy_pull <= 1'b1;
          step      <= 0;
        end else if (step == 5 && addr_in == NVS_SEQ_RECALL) begin
          mode <= 2'h2;
          cnt  <= RECALL_CYC;
          step <= 0;
        end else if (step < 5 && addr_in == SEQ[step]) begin
          step <= step + 1;
        end else begin
          step <= (addr_in == NVS_SEQ0) ? 1 : 0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/nvs_ctrl_tb_top.sv
// nvs_ctrl_tb_top: bench for the host controller against the device model
`timescale 1ns/1ps
`default_nettype none
module nvs_ctrl_tb_top
  import nvs_pkg::*;
;
  logic              mclk = 1'b0;
  logic              rst;
  logic              cmd_valid;
  logic              cmd_ready;
  nvs_cmd_t          cmd;
  logic              resp_valid;
  logic [NVS_DW-1:0] resp_rdata;
  logic              resp_err;
  logic [NVS_AW-1:0] addr_in;
  logic [NVS_DW-1:0] data_io_in;
  logic [NVS_DW-1:0] data_io_out;
  logic              data_io_oe_n;
  logic              chip_select_n;
  logic              write_enable_n;
  logic              output_enable_n;
  logic              busy_pin;
  logic              busy_out;
  logic              busy_oe_n;
  logic [NVS_DW-1:0] dev_dq;
  logic              dev_drv;
  logic              dev_pull;
  logic              pwr_low;
  logic              busy_seen;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cyc = 0;

  always #12.5 mclk = ~mclk;

  // shared data wire and pulled-up open-drain busy line
  assign data_io_in = !data_io_oe_n ? data_io_out : dev_dq;
  assign busy_pin   = (busy_oe_n || busy_out) && !dev_pull;

  nvs_ctrl #(.PWRUP_CYC(NVS_TW'(20)), .STORE_CYC(NVS_TW'(50))) DUT (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .resp_err(resp_err), .addr_in(addr_in), .data_io_in(data_io_in),
    .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n),
    .chip_select_n(chip_select_n), .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n), .hw_nv_request_busy_n_in(busy_pin),
    .hw_nv_request_busy_n_out(busy_out),
    .hw_nv_request_busy_n_oe_n(busy_oe_n));

  nvs_dev_model dev (
    .mclk(mclk), .rst(rst), .pwr_low(pwr_low), .addr_in(addr_in),
    .chip_select_n(chip_select_n), .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n), .dq_in(data_io_in),
    .busy_pin(busy_pin), .dq_out(dev_dq), .dq_drv(dev_drv),
    .busy_pull(dev_pull));

  // remember any busy low seen while a command runs
  always @(posedge mclk) if (busy_pin === 1'b0) busy_seen <= 1'b1;

  // both ends driving the data wire at once would corrupt the byte
  always @(posedge mclk) begin
    if (!rst) begin
      chk1("contention", 1'b0, dev_drv && !data_io_oe_n);
    end
  end

  // cut a hang short; the whole run needs a few thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  // one command: held until accepted, then wait for its one-cycle answer
  task automatic run(input nvs_op_t op, input logic [12:0] a,
                     input logic [7:0] d);
    int i;
    cmd_valid <= 1'b1;
    cmd       <= '{op, a, d};
    @(posedge mclk);
    for (i = 0; i < 2000 && cmd_ready !== 1'b1; i++) @(posedge mclk);
    cmd_valid <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 2000 && resp_valid !== 1'b1; i++) @(posedge mclk);
    chk1("resp_valid", 1'b1, resp_valid);
  endtask

  task automatic t_powerup();
    chk1("write_enable_n", 1'b1, write_enable_n);
    run(NVS_OP_READ, 13'h0123, 8'h00);
    chk8("powerup byte", 8'h23 ^ 8'h5A, resp_rdata);
  endtask

  task automatic t_rw();
    run(NVS_OP_WRITE, 13'h1ABC, 8'hC3);
    run(NVS_OP_WRITE, 13'h0ABC, 8'h3C);
    run(NVS_OP_READ, 13'h1ABC, 8'h00);
    chk8("read 1ABC", 8'hC3, resp_rdata);
    run(NVS_OP_READ, 13'h0ABC, 8'h00);
    chk8("read 0ABC", 8'h3C, resp_rdata);
  endtask

  task automatic t_sw();
    run(NVS_OP_WRITE, 13'h0100, 8'hA5);
    busy_seen = 1'b0;
    run(NVS_OP_SW_STORE, 13'h0000, 8'h00);
    chk1("save busy", 1'b1, busy_seen);
    chk1("resp_err", 1'b0, resp_err);
    run(NVS_OP_WRITE, 13'h0100, 8'h00);
    run(NVS_OP_SW_RECALL, 13'h0000, 8'h00);
    run(NVS_OP_READ, 13'h0100, 8'h00);
    chk8("loaded 0100", 8'hA5, resp_rdata);
  endtask

  // supply drop in mid-sequence with nothing written since the load
  task automatic t_auto();
    fork
      run(NVS_OP_SW_STORE, 13'h0000, 8'h00);
      begin
        repeat (8) @(posedge mclk);
        pwr_low <= 1'b1;
      end
    join
    chk1("resp_err", 1'b1, resp_err);
    run(NVS_OP_WRITE, 13'h0100, 8'h11);
    pwr_low <= 1'b0;
    run(NVS_OP_READ, 13'h0100, 8'h00);
    chk8("blocked 0100", 8'hA5, resp_rdata);
  endtask

  task automatic t_hw();
    run(NVS_OP_WRITE, 13'h0200, 8'h5E);
    busy_seen = 1'b0;
    run(NVS_OP_HW_STORE, 13'h0000, 8'h00);
    chk1("pin save busy", 1'b1, busy_seen);
    run(NVS_OP_WRITE, 13'h0200, 8'h00);
    run(NVS_OP_SW_RECALL, 13'h0000, 8'h00);
    run(NVS_OP_READ, 13'h0200, 8'h00);
    chk8("loaded 0200", 8'h5E, resp_rdata);
  endtask

  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    rst       = 1'b1;
    cmd_valid = 1'b0;
    cmd       = '0;
    pwr_low   = 1'b0;
    busy_seen = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_powerup();
    t_rw();
    t_sw();
    t_auto();
    t_hw();
    close_out();
  end
endmodule
`default_nettype wire
